// ---- dv/ssmp_host_model.sv ----
// host model: spi master, mode 3, msb first
// assumes one caller at a time; clk is the block clock
`timescale 1ns/1ps

module ssmp_host_model #(
  parameter int HALF = 4
) (
  // clock
  input wire logic clk,
  // link
  output logic spiCsN,
  output logic spiSck,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  // ==========
  // link idle, clock stands high between frames
  initial
  begin
    spiCsN = 1'b1;
    spiSck = 1'b1;
    spiMosi = 1'b0;
  end

  // one transfer, bits changed at sck fall, taken at rise
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    @(negedge clk);
    spiCsN = 1'b0;
    repeat (4) @(negedge clk);
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        spiSck = 1'b0;
        spiMosi = tx[i][k];
        repeat (HALF) @(negedge clk);
        b[k] = spiMisoOe ? spiMiso : ~spiMosi;
        spiSck = 1'b1;
        repeat (HALF) @(negedge clk);
      end
      rx.push_back(b);
    end
    spiCsN = 1'b1;
    spiMosi = ~spiMosi;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ---- dv/ssmp_pipes_chk.sv ----
// port-level checker for the message pipe block
// assumes bind onto ssmp_pipes, a single clock domain
`timescale 1ns/1ps

module ssmp_pipes_chk (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // pins
  input wire logic ifaceSelectLo,
  input wire logic ifaceSelectHi,
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic dataPendingOut,
  input wire logic dataPendingOe,
  // state and streams
  input wire ssmp_pkg::ssmp_iface_e ifaceMode,
  input wire logic runMode,
  input wire ssmp_pkg::ssmp_ctl_s ctlOut,
  input wire ssmp_pkg::ssmp_byte_s noteIn,
  input wire logic noteReady,
  input wire ssmp_pkg::ssmp_byte_s sampleIn,
  input wire logic sampleReady
);
  import ssmp_pkg::*;
  logic [2:0] upCnt;
  logic [1:0] selCap;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========
  // enabled edges since reset, saturating
  always_ff @(posedge clk or posedge rst)
    if (rst) upCnt <= 3'h0;
    else if (ce && upCnt != 3'h7) upCnt <= upCnt + 3'h1;

  // select pins as seen early after release
  always_ff @(posedge clk or posedge rst)
    if (rst) selCap <= 2'h3;
    else if (upCnt == 3'h1) selCap <= {ifaceSelectHi, ifaceSelectLo};

  // ==========
  // sequences
  sequence noteLast;
    noteIn.valid && noteReady && noteIn.last;
  endsequence
  sequence sampleLast;
    sampleIn.valid && sampleReady && sampleIn.last;
  endsequence
  sequence csIdle;
    spiCsN [*5];
  endsequence

  // ==========
  // assertions
  AST_MODE_SEL:
  assert property (upCnt == 3'h6 |-> ifaceMode == selCap) else $error("mode not taken from select pins");
  AST_MODE_HOLD:
  assert property (upCnt == 3'h7 |=> $stable(ifaceMode)) else $error("mode changed while running");
  AST_OE_MODE:
  assert property (ifaceMode != IF_SPI |-> !spiMisoOe) else $error("link driven outside spi mode");
  AST_SLAVE:
  assert property (csIdle |-> !spiMisoOe) else $error("link driven without chip select");
  AST_DONE_CS:
  assert property (ctlOut.done |-> spiCsN && $past(spiCsN, 2) && !ctlOut.valid) else $error("done inside frame");
  AST_CTL_VALID:
  assert property (ctlOut.valid |-> !$past(spiCsN, 3) ##1 !ctlOut.valid) else $error("bad control byte pulse");
  AST_NOTE_LOAD:
  assert property (noteLast |=> !noteReady [*3]) else $error("notice pipe open after message");
  AST_SAMPLE_LOAD:
  assert property (sampleLast |=> !sampleReady [*3]) else $error("sample pipe open after message");
  AST_SAMPLE_RUN:
  assert property (!runMode && !$past(runMode) |-> !sampleReady) else $error("samples taken in setup mode");
  AST_RUN_SWITCH:
  assert property ($changed(runMode) |-> ctlOut.done && ctlOut.sumOk) else $error("mode switch without message");
  AST_PEND_DRIVE:
  assert property (dataPendingOut |-> dataPendingOe) else $error("pending high while undriven");
endmodule

// ---- dv/tb_sync_serial_message_pipes.sv ----
// self-checking bench for the message pipe block over the spi link
// assumes design, checker and host model compiled first
`timescale 1ns/1ps
`include "ssmp_defs.svh"

module tb_sync_serial_message_pipes;
  import ssmp_pkg::*;
  localparam logic [7:0] VER = 8'h01; // arbitrary value
  localparam logic [7:0] RUN_ID = 8'h01;
  localparam logic [7:0] SETUP_ID = 8'h02;
  localparam int LIMIT = 30000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] lastCtl = 8'h00;
  logic ifaceSelectLo = 1'b1;
  logic ifaceSelectHi = 1'b1;
  logic spiCsN, spiSck, spiMosi, spiMiso, spiMisoOe;
  logic dataPendingOut, dataPendingOe, runMode, noteReady, sampleReady;
  ssmp_iface_e ifaceMode;
  ssmp_ctl_s ctlOut;
  ssmp_byte_s noteIn = '0;
  ssmp_byte_s sampleIn = '0;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int nCtl = 0;
  logic lastSum = 1'b0;
  logic [7:0] rx[$];
  wire pendPin = dataPendingOe ? dataPendingOut : 1'b1; // pull-up on the line

  // ==========
  // clock, cycle limit, control stream monitor
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (ctlOut.valid === 1'b1)
    begin
      nCtl <= nCtl + 1;
      lastCtl <= ctlOut.data;
    end
    if (ctlOut.done === 1'b1) lastSum <= ctlOut.sumOk;
    if (cycles == LIMIT)
    begin
      nErrors = nErrors + 1;
      finish_test();
    end
  end

  ssmp_pipes #(.DEPTH(16), .AW(4), .PROTO_VERSION(VER), .RUN_MSG_ID(RUN_ID), .SETUP_MSG_ID(SETUP_ID)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .ifaceSelectLo(ifaceSelectLo), .ifaceSelectHi(ifaceSelectHi),
    .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .dataPendingOut(dataPendingOut), .dataPendingOe(dataPendingOe), .ifaceMode(ifaceMode), .runMode(runMode),
    .ctlOut(ctlOut), .noteIn(noteIn), .noteReady(noteReady), .sampleIn(sampleIn), .sampleReady(sampleReady));
  ssmp_host_model host (.clk(clk), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe));

  // ==========
  // shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // pins set first, then reset
  task automatic do_reset(input logic [1:0] sel);
    @(negedge clk);
    {ifaceSelectHi, ifaceSelectLo} = sel;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  task automatic xf(input logic [7:0] tx[$]);
    host.xfer(tx, rx);
  endtask

  // load one message into the notice or sample pipe
  task automatic load(input logic smp, input logic [7:0] msg[$]);
    foreach (msg[i])
    begin
      @(negedge clk);
      if (smp) sampleIn = {1'b1, i == msg.size() - 1, msg[i]};
      else noteIn = {1'b1, i == msg.size() - 1, msg[i]};
      repeat (100) if ((smp ? sampleReady : noteReady) !== 1'b1) @(negedge clk);
      check("pipe ready", {7'h0, (smp ? sampleReady : noteReady)}, 8'h01);
      @(posedge clk);
    end
    @(negedge clk);
    noteIn = '0;
    sampleIn = '0;
    repeat (3) @(negedge clk);
  endtask

  // ==========
  // scenarios
  task automatic t_select();
    logic [1:0] codes[4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    foreach (codes[i])
    begin
      do_reset(codes[i]);
      check("iface mode", {6'h0, ifaceMode}, {6'h0, codes[i]});
    end
    {ifaceSelectHi, ifaceSelectLo} = 2'b10;
    repeat (10) @(negedge clk);
    check("mode after pin change", {6'h0, ifaceMode}, 8'h00);
    xf('{`SSMP_OP_INFO, 8'h00});
    check("uart link reply", rx[1], 8'hff);
    do_reset(2'b10);
    $display("test select done");
  endtask

  task automatic t_config();
    logic [7:0] cfg[7] = '{8'h0c, 8'h01, 8'h08, 8'h05, 8'h07, 8'h03, 8'hf6};
    logic [1:0] pinOe[7] = '{2'b11, 2'b11, 2'b01, 2'b01, 2'b01, 2'b10, 2'b10};
    xf('{`SSMP_OP_INFO, 8'h00, 8'h00, 8'h00});
    check("version", rx[1], VER);
    check("config", rx[2], `SSMP_CFG_RESET);
    check("info repeat", rx[3], VER);
    check("pending empty", {6'h0, pendPin, dataPendingOe}, 8'h01);
    load(1'b0, '{8'h42});
    foreach (cfg[i])
    begin
      xf('{`SSMP_OP_CFG, cfg[i]});
      check("pending pin", {6'h0, pendPin, dataPendingOe}, {6'h0, pinOe[i]});
    end
    xf('{`SSMP_OP_INFO, 8'h00, 8'h00});
    check("config readback", rx[2], 8'h06);
    xf('{`SSMP_OP_CFG, 8'h0c});
    xf('{`SSMP_OP_SIZES, 8'h00, 8'h00, 8'h00, 8'h00});
    check("notice size lo", rx[1], 8'h01);
    check("notice size hi", rx[2], 8'h00);
    check("sample size", rx[3], 8'h00);
    xf('{`SSMP_OP_NOTICE, 8'h00, 8'h00});
    check("notice byte", rx[1], 8'h42);
    check("notice repeat", rx[2], 8'h42);
    repeat (6) @(negedge clk);
    check("pending after read", {7'h0, pendPin}, 8'h00);
    $display("test config done");
  endtask

  task automatic t_control();
    int n0;
    n0 = nCtl;
    ce = 1'b0;
    xf('{`SSMP_OP_CTL, RUN_ID, 8'h00, 8'h00 - 8'hff - RUN_ID});
    ce = 1'b1;
    check("frozen control bytes", 8'(nCtl - n0), 8'h00);
    check("frozen run mode", {7'h0, runMode}, 8'h00);
    xf('{`SSMP_OP_CTL, RUN_ID, 8'h00, 8'h00 - 8'hff - RUN_ID});
    check("control bytes", 8'(nCtl - n0), 8'h03);
    check("control last byte", lastCtl, 8'h00 - 8'hff - RUN_ID);
    check("checksum ok", {7'h0, lastSum}, 8'h01);
    check("run mode", {7'h0, runMode}, 8'h01);
    $display("test control done");
  endtask

  task automatic t_sample();
    load(1'b1, '{8'h36, 8'h81});
    check("pending sample", {7'h0, pendPin}, 8'h01);
    xf('{`SSMP_OP_CFG, 8'h04});
    check("sample event off", {7'h0, pendPin}, 8'h00);
    xf('{`SSMP_OP_CFG, 8'h0c});
    xf('{`SSMP_OP_SIZES, 8'h00, 8'h00, 8'h00, 8'h00});
    check("notice size", rx[1], 8'h00);
    check("sample size lo", rx[3], 8'h02);
    check("sample size hi", rx[4], 8'h00);
    xf('{`SSMP_OP_SAMPLE, 8'h00, 8'h00});
    check("sample byte 0", rx[1], 8'h36);
    check("sample byte 1", rx[2], 8'h81);
    repeat (6) @(negedge clk);
    check("pending cleared", {7'h0, pendPin}, 8'h00);
    xf('{`SSMP_OP_CTL, SETUP_ID, 8'h00, 8'h00});
    check("bad checksum", {7'h0, lastSum}, 8'h00);
    check("mode kept", {7'h0, runMode}, 8'h01);
    xf('{`SSMP_OP_CTL, SETUP_ID, 8'h00, 8'h00 - 8'hff - SETUP_ID});
    check("setup mode", {7'h0, runMode}, 8'h00);
    $display("test sample done");
  endtask

  // ==========
  // main sequence
  initial
  begin
    t_select();
    t_config();
    t_control();
    t_sample();
    finish_test();
  end
endmodule

bind ssmp_pipes ssmp_pipes_chk chk (.clk(clk), .rst(rst), .ce(ce), .ifaceSelectLo(ifaceSelectLo),
  .ifaceSelectHi(ifaceSelectHi), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso),
  .spiMisoOe(spiMisoOe), .dataPendingOut(dataPendingOut), .dataPendingOe(dataPendingOe), .ifaceMode(ifaceMode),
  .runMode(runMode), .ctlOut(ctlOut), .noteIn(noteIn), .noteReady(noteReady), .sampleIn(sampleIn),
  .sampleReady(sampleReady));

// ---- src/ssmp_defs.svh ----
// constants of the synchronous serial message pipes: opcodes, config layout, resets
// assumes inclusion by bare name from any file that needs the figures
`ifndef SSMP_DEFS_SVH
`define SSMP_DEFS_SVH

// ==========================================================
// opcodes, first byte of every transfer
`define SSMP_OP_INFO 8'h01
`define SSMP_OP_CFG 8'h02
`define SSMP_OP_CTL 8'h03
`define SSMP_OP_SIZES 8'h04
`define SSMP_OP_NOTICE 8'h05
`define SSMP_OP_SAMPLE 8'h06

// ==========================================================
// pending line config byte
`define SSMP_CFG_RESET 8'h0c
`define SSMP_CFG_USED_MASK 8'h0f

// ==========================================================
// reply lengths in bytes
`define SSMP_INFO_LEN 16'h0002
`define SSMP_SIZES_LEN 16'h0004

// ==========================================================
// checksum seed, the dropped identifier byte
`define SSMP_LINK_IDENT 8'hff

// ==========================================================
// start-up select sampling
`define SSMP_SEL_SETTLE 2'h3
`define SSMP_SEL_RESET 2'h3

`endif

// ---- src/ssmp_msg_ram.sv ----
// byte memory holding one pending message of a pipe
// assumes one write port and one registered read port on the same clock
`timescale 1ns/1ps

module ssmp_msg_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // clock
  input wire logic clk,
  input wire logic ce,
  // write side
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read side
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (wrEn)
      begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule

// ---- src/ssmp_pipes.sv ----
// slave protocol layer: opcode-framed control, notice and sample pipes over a serial link
// assumes link pins asynchronous to clk, link clock at least 8 clk periods long
//
// Function
// - after start-up, select pins pick I2C 11, SPI 10, UART half 01, full 00
// - unconnected select pins read high, so the device comes up on I2C
// - UART passes messages as-is; I2C and SPI use the pipe protocol
// - host starts every transfer; device only answers as slave
// - all bytes of one transfer form exactly one message for the input queue; code passes only the bytes after a 0x03 opcode to ctlOut
// - interpreter responses go to the notice pipe for the host to read
// - control messages switch run mode; in run mode samples enter sample pipe
// - size reply gives next notice and next sample message lengths separately
// - default pending line low when empty, high while any message is pending
// - first byte is an opcode that decides type and format of the rest
// - 0x02 writes protocol config, 0x03 writes one reduced control message
// - 0x04 reads sizes, 0x05 reads notice message, 0x06 reads sample message
// - 0x01 reads two bytes: protocol version, then pending line config
// - reduced messages drop preamble and identifier bytes in both directions
// - checksum counts the dropped identifier as 0xff
// - config bit 3 enables pending events from the sample pipe
// - config bit 2 enables pending events from the notice pipe
// - config bit 1 selects push-pull at 0 or open-drain at 1
// - config bit 0 sets idle level: 0 idle low, 1 idle high
// - config bits 7 to 4 are reserved and change nothing
// - config write carries one byte that replaces the active config
// - size reply is two little-endian 16-bit words, notice first
// - every byte after control opcode belongs to one reduced message
`timescale 1ns/1ps
`include "ssmp_defs.svh"

module ssmp_pipes #(
  parameter int DEPTH = 512,
  parameter int AW = 9,
  parameter logic [7:0] PROTO_VERSION = 8'h01, // arbitrary value
  parameter logic [7:0] RUN_MSG_ID = 8'h01,
  parameter logic [7:0] SETUP_MSG_ID = 8'h02
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // select pins
  input wire logic ifaceSelectLo,
  input wire logic ifaceSelectHi,
  // link pins
  input wire logic spiCsN,
  input wire logic spiSck,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  // pending line
  output logic dataPendingOut,
  output logic dataPendingOe,
  // device state
  output ssmp_pkg::ssmp_iface_e ifaceMode,
  output logic runMode,
  // control messages toward the interpreter
  output ssmp_pkg::ssmp_ctl_s ctlOut,
  // messages from the interpreter and the sampler
  input wire ssmp_pkg::ssmp_byte_s noteIn,
  output logic noteReady,
  input wire ssmp_pkg::ssmp_byte_s sampleIn,
  output logic sampleReady
);
  import ssmp_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic csNS, sckS, mosiS, selLoS, selHiS;
  logic sckPrev, csPrev;
  logic sckRise, sckFall, csRise;

  // two flops on every pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA <= 5'h1b; // selects, sck and chip select at their idle high
      syncB <= 5'h1b;
      sckPrev <= 1'b1;
      csPrev <= 1'b1;
    end
    else if (ce)
    begin
      syncA <= {ifaceSelectHi, ifaceSelectLo, spiMosi, spiSck, spiCsN};
      syncB <= syncA;
      sckPrev <= sckS;
      csPrev <= csNS;
    end
  end

  assign csNS = syncB[0];
  assign sckS = syncB[1];
  assign mosiS = syncB[2];
  assign selLoS = syncB[3];
  assign selHiS = syncB[4];
  assign sckRise = sckS & ~sckPrev;
  assign sckFall = ~sckS & sckPrev;
  assign csRise = csNS & ~csPrev;

  // ==========================================================
  // interface selection at start-up
  logic [1:0] settleCnt;
  logic selDone;

  // catch the pins once, after the synchroniser has filled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      settleCnt <= 2'h0;
      selDone <= 1'b0;
      ifaceMode <= ssmp_iface_e'(`SSMP_SEL_RESET);
    end
    else if (ce && !selDone)
    begin
      if (settleCnt == `SSMP_SEL_SETTLE)
      begin
        ifaceMode <= ssmp_iface_e'({selHiS, selLoS});
        selDone <= 1'b1;
      end
      else
      begin
        settleCnt <= settleCnt + 2'h1;
      end
    end
  end

  // ==========================================================
  // transfer framing
  ssmp_xfer_e state;
  logic [7:0] opcode;
  logic [2:0] bitCnt;
  logic [6:0] rxShift;
  logic [7:0] rxByte;
  logic csLow, byteDone, dataDone, endOfData;
  logic [15:0] dataIdx;

  assign csLow = ~csNS & selDone & (ifaceMode == IF_SPI);
  assign rxByte = {rxShift, mosiS};
  assign byteDone = sckRise & csLow & (bitCnt == 3'h7) & (state != ST_IDLE);
  assign dataDone = byteDone & (state == ST_DATA);
  assign endOfData = csRise & (state == ST_DATA);

  // phase of the transfer, opcode first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      opcode <= 8'h00;
    end
    else if (ce)
    begin
      if (csNS)
      begin
        state <= ST_IDLE;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            if (csLow)
            begin
              state <= ST_OPCODE;
            end
          end
          ST_OPCODE:
          begin
            if (byteDone)
            begin
              state <= ST_DATA;
              opcode <= rxByte;
            end
          end
          ST_DATA:
          begin
            state <= ST_DATA;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // bit and byte counting on rising link clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bitCnt <= 3'h0;
      rxShift <= 7'h00;
      dataIdx <= 16'h0000;
    end
    else if (ce)
    begin
      if (state == ST_IDLE)
      begin
        bitCnt <= 3'h0;
        dataIdx <= 16'h0000;
      end
      else if (sckRise && csLow)
      begin
        bitCnt <= bitCnt + 3'h1;
        rxShift <= rxByte[6:0];
        if (dataDone)
        begin
          dataIdx <= dataIdx + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // protocol configuration
  ssmp_cfg_s cfg;

  // one data byte replaces the config
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg <= ssmp_cfg_s'(`SSMP_CFG_RESET);
    end
    else if (ce && dataDone && opcode == `SSMP_OP_CFG && dataIdx == 16'h0000)
    begin
      cfg <= ssmp_cfg_s'(rxByte & `SSMP_CFG_USED_MASK);
    end
  end

  // ==========================================================
  // control pipe toward the interpreter
  logic [7:0] ctlSum;
  logic [7:0] msgId;
  logic ctlEnd;

  assign ctlEnd = endOfData & (opcode == `SSMP_OP_CTL) & (dataIdx != 16'h0000);

  // stream bytes, close the message at chip-select release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctlOut <= '0;
      ctlSum <= `SSMP_LINK_IDENT;
      msgId <= 8'h00;
      runMode <= 1'b0;
    end
    else if (ce)
    begin
      ctlOut.valid <= 1'b0;
      ctlOut.done <= 1'b0;
      if (state == ST_OPCODE)
      begin
        ctlSum <= `SSMP_LINK_IDENT;
      end
      else if (dataDone && opcode == `SSMP_OP_CTL)
      begin
        ctlOut.valid <= 1'b1;
        ctlOut.data <= rxByte;
        ctlSum <= ctlSum + rxByte;
        if (dataIdx == 16'h0000)
        begin
          msgId <= rxByte;
        end
      end
      if (ctlEnd)
      begin
        ctlOut.done <= 1'b1;
        ctlOut.sumOk <= (ctlSum == 8'h00);
        if (ctlSum == 8'h00 && msgId == RUN_MSG_ID)
        begin
          runMode <= 1'b1;
        end
        else if (ctlSum == 8'h00 && msgId == SETUP_MSG_ID)
        begin
          runMode <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // notice (0) and sample (1) pipes
  ssmp_byte_s pipeIn [2];
  logic [1:0] full, readyR, accept, allow, drain;
  logic [15:0] wrIdx [2];
  logic [15:0] lenR [2];
  logic [15:0] shownLen [2];
  logic [7:0] ramRd [2];
  logic [15:0] rdIdx;
  logic readAll;

  assign pipeIn[0] = noteIn;
  assign pipeIn[1] = sampleIn;
  assign allow[0] = 1'b1;
  assign allow[1] = runMode;
  assign drain[0] = endOfData & (opcode == `SSMP_OP_NOTICE) & readAll & full[0];
  assign drain[1] = endOfData & (opcode == `SSMP_OP_SAMPLE) & readAll & full[1];
  assign noteReady = readyR[0];
  assign sampleReady = readyR[1];

  for (genvar i = 0; i < 2; i++)
  begin : gPipe
    assign accept[i] = pipeIn[i].valid & readyR[i];
    assign shownLen[i] = full[i] ? lenR[i] : 16'h0000;

    // load one message, hold it until the host has read it all
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        full[i] <= 1'b0;
        readyR[i] <= 1'b0;
        wrIdx[i] <= 16'h0000;
        lenR[i] <= 16'h0000;
      end
      else if (ce)
      begin
        readyR[i] <= allow[i] & ~(full[i] & ~drain[i]) & ~(accept[i] & pipeIn[i].last);
        if (drain[i])
        begin
          full[i] <= 1'b0;
        end
        else if (accept[i] && pipeIn[i].last)
        begin
          full[i] <= 1'b1;
          lenR[i] <= wrIdx[i] + 16'h0001;
        end
        if (accept[i])
        begin
          wrIdx[i] <= pipeIn[i].last ? 16'h0000 : wrIdx[i] + 16'h0001;
        end
      end
    end

    ssmp_msg_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) uRam (
      .clk(clk),
      .ce(ce),
      .wrEn(accept[i]),
      .wrAddr(wrIdx[i][AW-1:0]),
      .wrData(pipeIn[i].data),
      .rdAddr(rdIdx[AW-1:0]),
      .rdData(ramRd[i])
    );
  end

  // ==========================================================
  // read replies
  logic [15:0] rdLimit;
  logic [7:0] txByte;
  logic isRead;

  // reply length and byte for the active opcode
  always_comb
  begin
    rdLimit = 16'h0000;
    txByte = 8'h00;
    isRead = 1'b1;
    unique case (opcode)
      `SSMP_OP_INFO:
      begin
        rdLimit = `SSMP_INFO_LEN;
        txByte = rdIdx[0] ? 8'(cfg) : PROTO_VERSION;
      end
      `SSMP_OP_SIZES:
      begin
        rdLimit = `SSMP_SIZES_LEN;
        unique case (rdIdx[1:0])
          2'h0: txByte = shownLen[0][7:0];
          2'h1: txByte = shownLen[0][15:8];
          2'h2: txByte = shownLen[1][7:0];
          2'h3: txByte = shownLen[1][15:8];
        endcase
      end
      `SSMP_OP_NOTICE:
      begin
        rdLimit = shownLen[0];
        txByte = ramRd[0];
      end
      `SSMP_OP_SAMPLE:
      begin
        rdLimit = shownLen[1];
        txByte = ramRd[1];
      end
      default:
      begin
        isRead = 1'b0;
      end
    endcase
    if (state != ST_DATA || rdLimit == 16'h0000)
    begin
      txByte = 8'h00;
    end
  end

  // read index, restarts from the first byte after the last
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdIdx <= 16'h0000;
      readAll <= 1'b0;
    end
    else if (ce)
    begin
      if (state != ST_DATA)
      begin
        rdIdx <= 16'h0000;
        readAll <= 1'b0;
      end
      else if (dataDone && isRead)
      begin
        if (rdIdx + 16'h0001 >= rdLimit)
        begin
          rdIdx <= 16'h0000;
          readAll <= 1'b1;
        end
        else
        begin
          rdIdx <= rdIdx + 16'h0001;
        end
      end
    end
  end

  // shift out msb first on falling link clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      spiMiso <= 1'b0;
      spiMisoOe <= 1'b0;
    end
    else if (ce)
    begin
      spiMisoOe <= csLow;
      if (state == ST_IDLE)
      begin
        spiMiso <= 1'b0;
      end
      else if (sckFall)
      begin
        spiMiso <= txByte[~bitCnt];
      end
    end
  end

  // ==========================================================
  // pending line
  logic pending, level, pipeMode;

  // events count only on the synchronous links
  assign pipeMode = selDone & (ifaceMode == IF_SPI || ifaceMode == IF_I2C);
  assign pending = ((cfg.notifEventEn & full[0]) | (cfg.measEventEn & full[1])) & pipeMode;
  assign level = cfg.idleLevelSel ^ pending;

  // push-pull or open-drain drive
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataPendingOut <= 1'b0;
      dataPendingOe <= 1'b1;
    end
    else if (ce)
    begin
      dataPendingOut <= cfg.pinDriveType ? 1'b0 : level;
      dataPendingOe <= cfg.pinDriveType ? ~level : 1'b1;
    end
  end

endmodule

// ---- src/ssmp_pkg.sv ----
// types shared by the message pipe block and its surroundings
// assumes nothing beyond a SystemVerilog compiler
package ssmp_pkg;

  // interface chosen by the select pins, high pin first
  typedef enum logic [1:0]
  {
    IF_UART_FULL = 2'b00,
    IF_UART_HALF = 2'b01,
    IF_SPI = 2'b10,
    IF_I2C = 2'b11
  } ssmp_iface_e;

  // transfer phase on the link
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_OPCODE = 2'b01,
    ST_DATA = 2'b10
  } ssmp_xfer_e;

  // pending line configuration byte
  typedef struct packed
  {
    logic [3:0] reserved;
    logic measEventEn;
    logic notifEventEn;
    logic pinDriveType;
    logic idleLevelSel;
  } ssmp_cfg_s;

  // one byte of a message being loaded into a pipe
  typedef struct packed
  {
    logic valid;
    logic last;
    logic [7:0] data;
  } ssmp_byte_s;

  // control message stream toward the interpreter
  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
    logic done;
    logic sumOk;
  } ssmp_ctl_s;

endpackage
